// [hw/omd_pkg.sv]
package omd_pkg;
   // address map, 16-bit space
   localparam int          ADDR_W         = 16;
   localparam logic [15:0] ROM_BASE       = 16'h0000;
   localparam logic [15:0] ROM_TOP        = 16'h0fff;
   localparam logic [15:0] RAM_BASE       = 16'h1000;
   localparam logic [15:0] RAM_TOP        = 16'h1fff;
   localparam int          BANK_SEL_HI    = 11;
   localparam int          BANK_SEL_LO    = 10;
   localparam int          CHIP_ADDR_W    = 10;
   localparam int          NUM_BANKS      = 4;
   localparam logic [2:0]  REGION_TAG_POS = 3'h1;
   // reset values of the registered bank select and chip address outputs
   localparam logic [3:0]  BANK_SEL_RST   = 4'h0;
   localparam logic [9:0]  CHIP_ADDR_RST  = 10'h000;

   typedef enum logic [1:0]
   {
      OMD_REG_NONE = 2'b00,
      OMD_REG_ROM  = 2'b01,
      OMD_REG_RAM  = 2'b10
   } omd_region_e;

   // compares only the top four address bits, addr[15:12]
   function automatic omd_region_e omd_decode(input logic [15:0] addr);
      if (addr[15:12] == ROM_BASE[15:12])
         omd_decode = OMD_REG_ROM;
      else if (addr[15:12] == RAM_BASE[15:12])
         omd_decode = OMD_REG_RAM;
      else
         omd_decode = OMD_REG_NONE;
   endfunction : omd_decode
endpackage : omd_pkg

// [hw/omd_bank_decode.sv]
`timescale 1ns/100ps
module omd_bank_decode
   import omd_pkg::*;
#(
   parameter int BANKS = NUM_BANKS
)
(
   input  wire logic [1:0]       bank_idx,
   input  wire logic             enable,
   output logic      [BANKS-1:0] bank_onehot
);
   always_comb
   begin
      bank_onehot = '0;
      if (enable)
         bank_onehot[bank_idx] = 1'b1;
   end
endmodule : omd_bank_decode

// [hw/omd_decoder.sv]
`timescale 1ns/100ps
// Overview of operation
// - addresses 0000h to 0fffh select the on-board rom.
// - the boot rom chip always sits at address zero so the first fetch after reset hits it.
// - addresses 1000h to 1fffh select on-board ram.
// - ram is up to four 1k banks, each a pair of nibble chips sharing one select.
// - the top four address bits are fully decoded so the 8k region never aliases.
// - onboard_region_select flags accesses inside the 8k on-board region.
// - chip selects are qualified by memory read or write strobes and suppressed while any i/o strobe is active.
module omd_decoder
   import omd_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        sys_rst,
   input  wire logic [15:0] addr,
   input  wire logic        mem_rd,
   input  wire logic        mem_wr,
   input  wire logic        io_rd,
   input  wire logic        io_wr,
   output logic             rom_lo_sel,
   output logic             rom_hi_sel,
   output logic [3:0]       ram_bank_sel,
   output logic [9:0]       chip_addr,
   output logic             ram_wr,
   output logic             onboard_region_select
);
   ////////////////////////////////////////////////////////////////////////////
   omd_region_e region;
   logic        mem_cycle;
   logic [3:0]  next_bank;
   logic        next_rom_lo;
   logic        next_rom_hi;
   logic        next_ram_wr;
   logic        next_region;

   assign region    = omd_decode(addr);
   // any active i/o strobe blocks the memory cycle
   assign mem_cycle = (mem_rd | mem_wr) & ~(io_rd | io_wr);

   omd_bank_decode #(.BANKS(NUM_BANKS)) u_bank
   (
      .bank_idx    (addr[BANK_SEL_HI:BANK_SEL_LO]),
      .enable      (mem_cycle && region == OMD_REG_RAM),
      .bank_onehot (next_bank)
   );

   ////////////////////////////////////////////////////////////////////////////
   // next values of the single-bit selects
   always_comb
   begin
      next_rom_lo = 1'h0;
      next_rom_hi = 1'h0;
      next_ram_wr = 1'h0;
      next_region = 1'h0;
      if (mem_cycle)
      begin
         case (region)
            OMD_REG_ROM:
            begin
               // lower 2k chip holds address zero
               next_rom_lo = !addr[11];
               next_rom_hi = addr[11];
               next_region = 1'h1;
            end
            OMD_REG_RAM:
            begin
               // reads need no strobe of their own, the bank select suffices
               next_ram_wr = mem_wr;
               next_region = 1'h1;
            end
            default:
            begin
               // everything above the 8k region belongs to expansion memory
               next_rom_lo = 1'h0;
               next_rom_hi = 1'h0;
               next_ram_wr = 1'h0;
               next_region = 1'h0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // rom chip selects
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         rom_lo_sel <= 1'h0;
         rom_hi_sel <= 1'h0;
      end
      else
      begin
         rom_lo_sel <= next_rom_lo;
         rom_hi_sel <= next_rom_hi;
      end
   end

   // one select per bank pair, shared by both nibble chips of the bank
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         ram_bank_sel <= BANK_SEL_RST;
      else
         ram_bank_sel <= next_bank;
   end

   // chips share the low address bits whatever the region
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         chip_addr <= CHIP_ADDR_RST;
      else
         chip_addr <= addr[CHIP_ADDR_W-1:0];
   end

   // write strobe to the ram chips
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         ram_wr <= 1'h0;
      else
         ram_wr <= next_ram_wr;
   end

   // expansion boards decode around this flag
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         onboard_region_select <= 1'h0;
      else
         onboard_region_select <= next_region;
   end

   ////////////////////////////////////////////////////////////////////////////
   // sampled !sys_rst keeps the release edge, whose outputs stay reset, out
   AST_ROM_RANGE: assert property (@(posedge clock) disable iff (sys_rst)
      (!sys_rst && mem_cycle && addr <= ROM_TOP) |=> (rom_lo_sel || rom_hi_sel))
      else $error("rom not selected in rom range");

   AST_BOOT_ZERO: assert property (@(posedge clock) disable iff (sys_rst)
      (!sys_rst && mem_rd && !io_rd && !io_wr && addr == ROM_BASE) |=> rom_lo_sel)
      else $error("boot rom not selected at zero");

   AST_RAM_RANGE: assert property (@(posedge clock) disable iff (sys_rst)
      (!sys_rst && mem_cycle && addr >= RAM_BASE && addr <= RAM_TOP) |=> $onehot(ram_bank_sel))
      else $error("ram not selected in ram range");

   AST_ONE_CHIP: assert property (@(posedge clock) disable iff (sys_rst)
      $onehot0({rom_lo_sel, rom_hi_sel, ram_bank_sel}))
      else $error("more than one chip selected");

   AST_NO_ALIAS: assert property (@(posedge clock) disable iff (sys_rst)
      (addr > RAM_TOP) |=> !onboard_region_select && ram_bank_sel == 4'h0
                          && !rom_lo_sel && !rom_hi_sel)
      else $error("on-board region aliased");

   AST_REGION_FLAG: assert property (@(posedge clock) disable iff (sys_rst)
      onboard_region_select == $past(!sys_rst && mem_cycle && addr <= RAM_TOP))
      else $error("region select wrong");

   AST_IO_IGNORED: assert property (@(posedge clock) disable iff (sys_rst)
      (io_rd || io_wr || !(mem_rd || mem_wr)) |=> !onboard_region_select && !ram_wr)
      else $error("select during non-memory cycle");

   AST_BANK_BITS: assert property (@(posedge clock) disable iff (sys_rst)
      (!sys_rst && mem_cycle && addr[15:12] == 4'h1) |=>
         ram_bank_sel[$past(addr[11:10])] && chip_addr == $past(addr[9:0]))
      else $error("wrong bank or chip address");

   AST_ROM_HI_HALF: assert property (@(posedge clock) disable iff (sys_rst)
      (!sys_rst && mem_cycle && addr[15:11] == 5'h01) |=> rom_hi_sel && !rom_lo_sel)
      else $error("upper rom chip not selected");

   AST_ROM_LO_HALF: assert property (@(posedge clock) disable iff (sys_rst)
      (!sys_rst && mem_cycle && addr[15:11] == 5'h00) |=> rom_lo_sel && !rom_hi_sel)
      else $error("lower rom chip not selected");

   AST_ROM_ONLY: assert property (@(posedge clock) disable iff (sys_rst)
      (rom_lo_sel || rom_hi_sel) |-> $past(addr) <= ROM_TOP)
      else $error("rom selected outside rom range");

   AST_RAM_ONLY: assert property (@(posedge clock) disable iff (sys_rst)
      (ram_bank_sel != 4'h0) |-> ($past(addr) >= RAM_BASE && $past(addr) <= RAM_TOP))
      else $error("ram selected outside ram range");

   AST_WR_IN_BANK: assert property (@(posedge clock) disable iff (sys_rst)
      ram_wr |-> $onehot(ram_bank_sel))
      else $error("ram write without one bank selected");

   AST_WR_STROBE: assert property (@(posedge clock) disable iff (sys_rst)
      ram_wr |-> $past(mem_wr))
      else $error("ram write without memory write strobe");

   AST_WR_RANGE: assert property (@(posedge clock) disable iff (sys_rst)
      ram_wr |-> $past(addr[15:12]) == RAM_BASE[15:12])
      else $error("ram write outside ram range");

   AST_SEL_IN_REGION: assert property (@(posedge clock) disable iff (sys_rst)
      (rom_lo_sel || rom_hi_sel || ram_bank_sel != 4'h0) |-> onboard_region_select)
      else $error("chip selected without region select");

   AST_IO_NO_CHIP: assert property (@(posedge clock) disable iff (sys_rst)
      (!sys_rst && (io_rd || io_wr)) |=> !rom_lo_sel && !rom_hi_sel && ram_bank_sel == 4'h0)
      else $error("chip selected during i/o cycle");

   AST_RD_NO_WR: assert property (@(posedge clock) disable iff (sys_rst)
      (!sys_rst && mem_rd && !mem_wr) |=> !ram_wr)
      else $error("ram write on a read");

   AST_CHIP_ADDR: assert property (@(posedge clock) disable iff (sys_rst)
      !$past(sys_rst) |-> chip_addr == $past(addr[9:0]))
      else $error("chip address does not follow bus");

   AST_RESET_QUIET: assert property (@(posedge clock) disable iff (sys_rst)
      $past(sys_rst) |-> !rom_lo_sel && !rom_hi_sel && ram_bank_sel == BANK_SEL_RST
                         && !ram_wr && !onboard_region_select)
      else $error("outputs not quiet after reset");

   COV_ROM:    cover property (@(posedge clock) rom_lo_sel);
   COV_ROM_HI: cover property (@(posedge clock) rom_hi_sel);
   COV_RAM3:   cover property (@(posedge clock) ram_bank_sel[3] && ram_wr);
   COV_EXT:    cover property (@(posedge clock) mem_rd ##1 !onboard_region_select);
   COV_IO:     cover property (@(posedge clock) mem_wr && io_rd ##1 !ram_wr);
endmodule : omd_decoder

// [tb/omd_offboard.sv]
`timescale 1ns/100ps
module omd_offboard
   import omd_pkg::*;
(
   input  wire logic clock,
   input  wire logic mem_rd,
   input  wire logic mem_wr,
   input  wire logic io_rd,
   input  wire logic io_wr,
   input  wire logic onboard_region_select,
   output logic      offboard_sel
);
   logic cycle_q;
   always_ff @(posedge clock)
      cycle_q <= (mem_rd | mem_wr) & ~(io_rd | io_wr);
   // expansion memory answers only memory cycles outside the on-board 8k
   assign offboard_sel = cycle_q & ~onboard_region_select;
endmodule : omd_offboard

// [tb/onboard_memory_decoder_tb.sv]
`timescale 1ns/100ps
module onboard_memory_decoder_tb;
   import omd_pkg::*;
   logic        clock = 1'b0;
   logic        sys_rst = 1'b1;
   logic [15:0] addr = 16'h0000;
   logic        mem_rd = 1'b0, mem_wr = 1'b0, io_rd = 1'b0, io_wr = 1'b0;
   logic        rom_lo_sel, rom_hi_sel, ram_wr, onboard_region_select, offboard_sel;
   logic [3:0]  ram_bank_sel;
   logic [9:0]  chip_addr;
   logic [7:0]  got;
   logic [27:0] r;
   int          failures = 0;
   int          checked = 0;
   // addr, rd wr iord iowr, then rom_lo rom_hi bank[3:0] ram_wr region
   logic [27:0] rows [13] = '{28'h0000881, 28'h0fff841, 28'h07ff881, 28'h1000407,
      28'h17ff809, 28'h1bff811, 28'h1fff423, 28'h2000800, 28'h9000400, 28'h8000800,
      28'h1400600, 28'h0000900, 28'h1400000};
   always #20 clock = ~clock;
   omd_decoder i_dut (.clock(clock), .sys_rst(sys_rst), .addr(addr), .mem_rd(mem_rd),
      .mem_wr(mem_wr), .io_rd(io_rd), .io_wr(io_wr), .rom_lo_sel(rom_lo_sel),
      .rom_hi_sel(rom_hi_sel), .ram_bank_sel(ram_bank_sel), .chip_addr(chip_addr),
      .ram_wr(ram_wr), .onboard_region_select(onboard_region_select));
   omd_offboard i_far (.clock(clock), .mem_rd(mem_rd), .mem_wr(mem_wr), .io_rd(io_rd),
      .io_wr(io_wr), .onboard_region_select(onboard_region_select),
      .offboard_sel(offboard_sel));
   assign got = {rom_lo_sel, rom_hi_sel, ram_bank_sel, ram_wr, onboard_region_select};
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
      checked++;
      if (exp !== seen)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic end_sim;
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (4) @(posedge clock);
      sys_rst <= 1'b0;
      // rows go back to back; each edge checks the row driven one edge earlier
      for (int i = 0; i <= 13; i++)
      begin
         @(posedge clock);
         if (i < 13)
            {addr, mem_rd, mem_wr, io_rd, io_wr} <= rows[i][27:8];
         #1;
         if (i > 0)
         begin
            r = rows[i-1];
            chk("selects", {8'h00, r[7:0]}, {8'h00, got});
            chk("chip_addr", {6'h00, r[21:12]}, {6'h00, chip_addr});
            chk("offboard", {15'h0000, (r[11] | r[10]) & ~(r[9] | r[8]) & ~r[0]},
               {15'h0000, offboard_sel});
         end
      end
      // reset with a ram write pending, then the boot fetch right after release
      @(posedge clock);
      {addr, mem_rd, mem_wr, io_rd, io_wr, sys_rst} <= {16'h17ff, 5'h09};
      repeat (2) @(posedge clock);
      #1;
      chk("reset", 16'h0000, {8'h00, got});
      chk("reset chip_addr", {6'h00, CHIP_ADDR_RST}, {6'h00, chip_addr});
      @(posedge clock);
      {addr, mem_rd, mem_wr, sys_rst} <= {16'h0000, 3'h4};
      @(posedge clock);
      #1;
      chk("boot", 16'h0081, {8'h00, got});
      chk("boot chip_addr", 16'h0000, {6'h00, chip_addr});
      @(posedge clock);
      #1;
      chk("boot hold", 16'h0081, {8'h00, got});
      end_sim();
   end
endmodule : onboard_memory_decoder_tb
